//--- pkg/alrf_pkg.sv
// Purpose: shared constants, types and character helpers of the ascii link read framer
// Assumes: 8-bit ascii characters, 40 MHz clock
// Notes: all codes and positions used by the framer live here
package alrf_pkg;

   // control codes
   localparam logic [7:0] STX = 8'h02;
   localparam logic [7:0] ETX = 8'h03;
   localparam logic [7:0] ENQ = 8'h05;
   localparam logic [7:0] ACK = 8'h06;
   localparam logic [7:0] LF = 8'h0a;
   localparam logic [7:0] CR = 8'h0d;
   localparam logic [7:0] NAK = 8'h15;

   // waiting-time setting value that selects the delay digit in the request
   localparam logic [15:0] WAIT_FROM_DIGIT = 16'h270f;

   // timing
   localparam int CLK_KHZ = 40000;
   localparam int MS_TIME = 1;
   localparam int MS_CYCLES = CLK_KHZ * MS_TIME;
   localparam logic [15:0] DELAY_STEP_MS = 16'h000a;

   // request body lengths after the enquiry code and zero-based field indices
   localparam logic [2:0] BODY_WITH_DIGIT = 3'h7;
   localparam logic [2:0] BODY_NO_DIGIT = 3'h6;
   localparam logic [2:0] IDX_STATION_HI = 3'h0;
   localparam logic [2:0] IDX_STATION_LO = 3'h1;
   localparam logic [2:0] IDX_INSTR_HI = 3'h2;
   localparam logic [2:0] IDX_INSTR_LO = 3'h3;
   localparam logic [2:0] IDX_DELAY = 3'h4;

   // reply layout: zero-based character positions, body lengths and the largest data length
   localparam logic [4:0] POS_STATION_HI = 5'h01;
   localparam logic [4:0] POS_STATION_LO = 5'h02;
   localparam logic [4:0] POS_DATA = 5'h03;
   localparam logic [4:0] NAK_BODY_LEN = 5'h04;
   localparam logic [4:0] DATA_OVERHEAD = 5'h06;
   localparam int MAX_DATA = 20;

   // read reply formats
   localparam logic [1:0] FMT_FOUR = 2'h0;
   localparam logic [1:0] FMT_TWO = 2'h1;
   localparam logic [1:0] FMT_SIX = 2'h2;
   localparam logic [1:0] FMT_MODEL = 2'h3;

   // error codes
   localparam logic [3:0] ERR_SUM = 4'h2;
   localparam logic [3:0] ERR_CHAR = 4'h7;

   typedef enum logic [2:0] {S_IDLE, S_BODY, S_HOST, S_WAIT, S_SEND} alrf_state_type;

   function automatic logic is_hex(input logic [7:0] c);
      return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
   endfunction

   function automatic logic [3:0] hex_val(input logic [7:0] c);
      logic [7:0] v;
      v = (c >= 8'h41) ? c - 8'h37 : c - 8'h30;
      return v[3:0];
   endfunction

   function automatic logic [7:0] to_hex(input logic [3:0] v);
      return (v < 4'ha) ? 8'h30 + {4'h0, v} : 8'h37 + {4'h0, v};
   endfunction

   function automatic logic is_ctrl(input logic [7:0] c);
      return c == STX || c == ETX || c == ENQ || c == ACK || c == LF || c == CR || c == NAK;
   endfunction

   function automatic logic [4:0] data_len(input logic [1:0] f);
      case (f)
         FMT_TWO: return 5'h02;
         FMT_SIX: return 5'h06;
         FMT_MODEL: return 5'h14;
         default: return 5'h04;
      endcase
   endfunction

endpackage

//--- src/alrf_wait_timer.sv
// Purpose: millisecond down-counter for the reply waiting time
// Assumes: load is a one-cycle pulse on the framer clock
// Notes: done is high while idle and after the count has run out
`timescale 1ns/10ps
`default_nettype none
module alrf_wait_timer #(parameter int MS_CYCLES = alrf_pkg::MS_CYCLES)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [15:0] ms_count,
   output logic done
);
   logic [31:0] div;
   logic [15:0] remain;
   logic tick;

   assign tick = (div == 32'(MS_CYCLES - 1));

   // the divider restarts on load so the first millisecond is a full one
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div <= 32'h0;
         remain <= 16'h0;
         done <= 1'b1;
      end
      else if (load)
      begin
         div <= 32'h0;
         remain <= ms_count;
         done <= (ms_count == 16'h0);
      end
      else if (!done)
      begin
         div <= tick ? 32'h0 : div + 32'h1;
         if (tick)
         begin
            remain <= remain - 16'h1;
            if (remain == 16'h1)
               done <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

//--- src/alrf_read_framer.sv
// Purpose: frame logic of the ascii computer-link read transaction, device end
// Assumes: rx and tx characters come from a uart on the same clock
// Notes: instruction meaning and read data come from the application port
`timescale 1ns/10ps
`default_nettype none
module alrf_read_framer #(parameter int MS_CYCLES = alrf_pkg::MS_CYCLES)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rx_valid,
   input wire logic [7:0] rx_char,
   input wire logic tx_ready,
   output logic tx_valid,
   output logic [7:0] tx_char,
   input wire logic [4:0] station_id,
   input wire logic [15:0] reply_wait_time_setting,
   input wire logic [1:0] terminator_select_setting,
   output logic req_valid,
   output logic [15:0] req_instr,
   input wire logic rd_done,
   input wire logic [1:0] rd_format,
   input wire logic [159:0] rd_data,
   input wire logic rd_err,
   input wire logic [3:0] rd_err_code,
   output logic host_ack,
   output logic host_nak,
   output logic busy
);
   alrf_pkg::alrf_state_type state;
   logic [2:0] rx_idx;
   logic [7:0] st_hi, st_lo, dly_ch, sum_hi_ch;
   logic [7:0] rx_sum;
   logic char_err;
   logic host_is_nak;
   logic reply_nak, data_ready, have_reply;
   logic [3:0] nak_code;
   logic [1:0] fmt;
   logic [7:0] data_buf [0:alrf_pkg::MAX_DATA-1];
   logic [4:0] pos;
   logic [7:0] tx_sum;
   logic tmr_load, tmr_done;
   logic [15:0] tmr_ms;

   logic digit_mode, char_bad, last_rx, station_ok, bad_any, sum_ok;
   logic [2:0] body_len;
   logic [7:0] recv_sum;
   logic [4:0] n, body_end, frame_len;
   logic [7:0] cur_char;
   logic send_go, load, tx_done;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   assign digit_mode = (reply_wait_time_setting == alrf_pkg::WAIT_FROM_DIGIT);
   assign body_len = digit_mode ? alrf_pkg::BODY_WITH_DIGIT : alrf_pkg::BODY_NO_DIGIT;
   assign char_bad = !(alrf_pkg::is_hex(rx_char) || alrf_pkg::is_ctrl(rx_char));
   assign last_rx = rx_valid && state == alrf_pkg::S_BODY && rx_char != alrf_pkg::ENQ
      && rx_idx == body_len - 3'h1;
   assign station_ok = alrf_pkg::is_hex(st_hi) && alrf_pkg::is_hex(st_lo)
      && {alrf_pkg::hex_val(st_hi), alrf_pkg::hex_val(st_lo)} == {3'h0, station_id};
   assign bad_any = char_err || char_bad;
   assign recv_sum = {alrf_pkg::hex_val(sum_hi_ch), alrf_pkg::hex_val(rx_char)};
   assign sum_ok = (recv_sum == rx_sum);

   // frame sequencing
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         state <= alrf_pkg::S_IDLE;
      else
      begin
         case (state)
            alrf_pkg::S_IDLE:
               if (rx_valid && rx_char == alrf_pkg::ENQ)
                  state <= alrf_pkg::S_BODY;
               else if (rx_valid && (rx_char == alrf_pkg::ACK || rx_char == alrf_pkg::NAK))
                  state <= alrf_pkg::S_HOST;
            alrf_pkg::S_BODY:
               if (last_rx)
                  state <= station_ok ? alrf_pkg::S_WAIT : alrf_pkg::S_IDLE;
            alrf_pkg::S_HOST:
               if (rx_valid && rx_char == alrf_pkg::ENQ)
                  state <= alrf_pkg::S_BODY;
               else if (rx_valid && rx_idx == alrf_pkg::IDX_STATION_LO)
               begin
                  // a host nak asks for the same read reply again
                  if (host_is_nak && have_reply && alrf_pkg::is_hex(rx_char)
                      && {alrf_pkg::hex_val(st_hi), alrf_pkg::hex_val(rx_char)} == {3'h0, station_id})
                     state <= alrf_pkg::S_SEND;
                  else
                     state <= alrf_pkg::S_IDLE;
               end
            alrf_pkg::S_WAIT:
               // done still shows the idle level while the load is in flight
               if (tmr_done && data_ready && !tmr_load)
                  state <= alrf_pkg::S_SEND;
            alrf_pkg::S_SEND:
               if (tx_done)
                  state <= alrf_pkg::S_IDLE;
            default:
               state <= alrf_pkg::S_IDLE;
         endcase
      end
   end

   // request field capture and running sum
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_idx <= 3'h0;
         st_hi <= 8'h0;
         st_lo <= 8'h0;
         dly_ch <= 8'h0;
         sum_hi_ch <= 8'h0;
         rx_sum <= 8'h0;
         char_err <= 1'b0;
         req_instr <= 16'h0;
         host_is_nak <= 1'b0;
      end
      else if (rx_valid)
      begin
         if (rx_char == alrf_pkg::ENQ || state == alrf_pkg::S_IDLE)
         begin
            // an enquiry restarts a frame except in S_WAIT and S_SEND, where it clears the capture but the state stays
            rx_idx <= 3'h0;
            rx_sum <= 8'h0;
            char_err <= 1'b0;
            host_is_nak <= (rx_char == alrf_pkg::NAK);
         end
         else if (state == alrf_pkg::S_BODY || state == alrf_pkg::S_HOST)
         begin
            rx_idx <= rx_idx + 3'h1;
            char_err <= char_err || char_bad;
            if (rx_idx < body_len - 3'h2)
               rx_sum <= rx_sum + rx_char;
            if (rx_idx == alrf_pkg::IDX_STATION_HI)
               st_hi <= rx_char;
            if (rx_idx == alrf_pkg::IDX_STATION_LO)
               st_lo <= rx_char;
            if (rx_idx == alrf_pkg::IDX_INSTR_HI)
               req_instr[15:8] <= rx_char;
            if (rx_idx == alrf_pkg::IDX_INSTR_LO)
               req_instr[7:0] <= rx_char;
            if (digit_mode && rx_idx == alrf_pkg::IDX_DELAY)
               dly_ch <= rx_char;
            if (rx_idx == body_len - 3'h2)
               sum_hi_ch <= rx_char;
         end
      end
   end

   // waiting time: digit times 10 ms, or the configured time
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tmr_load <= 1'b0;
         tmr_ms <= 16'h0;
      end
      else
      begin
         tmr_load <= last_rx && station_ok;
         if (last_rx)
            tmr_ms <= digit_mode ? 16'(alrf_pkg::hex_val(dly_ch)) * alrf_pkg::DELAY_STEP_MS
                                 : reply_wait_time_setting;
      end
   end

   alrf_wait_timer #(.MS_CYCLES(MS_CYCLES)) u_timer
   (
      .clk(clk),
      .rst_n(rst_n),
      .load(tmr_load),
      .ms_count(tmr_ms),
      .done(tmr_done)
   );

   // reply content: error code or read data from the application
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reply_nak <= 1'b0;
         nak_code <= 4'h0;
         data_ready <= 1'b0;
         fmt <= alrf_pkg::FMT_FOUR;
         have_reply <= 1'b0;
         for (int i = 0; i < alrf_pkg::MAX_DATA; i++)
            data_buf[i] <= 8'h0;
      end
      else if (last_rx && station_ok)
      begin
         have_reply <= 1'b0;
         reply_nak <= bad_any || !sum_ok;
         nak_code <= bad_any ? alrf_pkg::ERR_CHAR : alrf_pkg::ERR_SUM;
         data_ready <= bad_any || !sum_ok;
      end
      else if (state == alrf_pkg::S_WAIT && rd_done && !data_ready)
      begin
         // the application ends its processing time with rd_done
         data_ready <= 1'b1;
         reply_nak <= rd_err;
         nak_code <= rd_err_code;
         fmt <= rd_format;
         for (int i = 0; i < alrf_pkg::MAX_DATA; i++)
            data_buf[i] <= rd_data[159 - 8 * i -: 8];
      end
      else if (tx_done)
         have_reply <= !reply_nak;
      else if (host_ack)
         have_reply <= 1'b0;
   end

   // reply character at the current position
   always_comb
   begin
      n = alrf_pkg::data_len(fmt);
      body_end = reply_nak ? alrf_pkg::NAK_BODY_LEN : n + alrf_pkg::DATA_OVERHEAD;
      frame_len = body_end + {4'h0, terminator_select_setting[0]}
                  + {4'h0, terminator_select_setting[1]};
      if (pos == 5'h0)
         cur_char = reply_nak ? alrf_pkg::NAK : alrf_pkg::STX;
      else if (pos == alrf_pkg::POS_STATION_HI)
         cur_char = alrf_pkg::to_hex({3'h0, station_id[4]});
      else if (pos == alrf_pkg::POS_STATION_LO)
         cur_char = alrf_pkg::to_hex(station_id[3:0]);
      else if (pos < body_end)
      begin
         if (reply_nak)
            cur_char = alrf_pkg::to_hex(nak_code);
         else if (pos < alrf_pkg::POS_DATA + n)
            cur_char = data_buf[5'(pos - alrf_pkg::POS_DATA)];
         else if (pos == alrf_pkg::POS_DATA + n)
            cur_char = alrf_pkg::ETX;
         else if (pos == alrf_pkg::POS_DATA + n + 5'h1)
            cur_char = alrf_pkg::to_hex(tx_sum[7:4]);
         else
            cur_char = alrf_pkg::to_hex(tx_sum[3:0]);
      end
      else if (pos == body_end && terminator_select_setting[0])
         cur_char = alrf_pkg::CR;
      else
         cur_char = alrf_pkg::LF;
   end

   assign send_go = (state == alrf_pkg::S_SEND) && (!tx_valid || tx_ready);
   assign load = send_go && pos < frame_len;
   assign tx_done = send_go && pos == frame_len;

   // transmit register; a character waits in tx_char until tx_ready takes it
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pos <= 5'h0;
         tx_sum <= 8'h0;
         tx_valid <= 1'b0;
         tx_char <= 8'h0;
      end
      else if (state != alrf_pkg::S_SEND || tx_done)
      begin
         pos <= 5'h0;
         tx_sum <= 8'h0;
         tx_valid <= 1'b0;
      end
      else if (load)
      begin
         tx_char <= cur_char;
         tx_valid <= 1'b1;
         pos <= pos + 5'h1;
         if (pos != 5'h0 && pos <= alrf_pkg::POS_DATA + n)
            tx_sum <= tx_sum + cur_char;
      end
   end

   // one-cycle event outputs and the registered busy level
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         req_valid <= 1'b0;
         host_ack <= 1'b0;
         host_nak <= 1'b0;
         busy <= 1'b0;
      end
      else
      begin
         req_valid <= last_rx && station_ok && !bad_any && sum_ok;
         host_ack <= state == alrf_pkg::S_HOST && rx_valid && rx_idx == alrf_pkg::IDX_STATION_LO
            && !host_is_nak && alrf_pkg::is_hex(rx_char)
            && {alrf_pkg::hex_val(st_hi), alrf_pkg::hex_val(rx_char)} == {3'h0, station_id};
         host_nak <= state == alrf_pkg::S_HOST && rx_valid && rx_idx == alrf_pkg::IDX_STATION_LO
            && host_is_nak && alrf_pkg::is_hex(rx_char)
            && {alrf_pkg::hex_val(st_hi), alrf_pkg::hex_val(rx_char)} == {3'h0, station_id};
         busy <= (state == alrf_pkg::S_WAIT) || (state == alrf_pkg::S_SEND);
      end
   end

   wait_gate_a: assert property ((state == alrf_pkg::S_WAIT && !(tmr_done && data_ready))
      |=> state != alrf_pkg::S_SEND) else $error("reply started before wait and data");
   frame_open_a: assert property (load && pos == 5'h0
      |=> tx_valid && tx_char == (reply_nak ? alrf_pkg::NAK : alrf_pkg::STX))
      else $error("reply opened with wrong control code");
   station_out_a: assert property (load && pos == alrf_pkg::POS_STATION_HI
      |=> tx_char == (station_id[4] ? 8'h31 : 8'h30))
      else $error("station high digit wrong");
   etx_place_a: assert property (load && !reply_nak && pos == alrf_pkg::POS_DATA + n
      |=> tx_char == alrf_pkg::ETX) else $error("etx not right after data");
   nak_code_a: assert property (load && reply_nak && pos == alrf_pkg::POS_DATA
      |=> tx_char == alrf_pkg::to_hex(nak_code)) else $error("error code misplaced");
   sum_err_a: assert property (last_rx && station_ok && !bad_any && !sum_ok
      |=> reply_nak && nak_code == alrf_pkg::ERR_SUM && state == alrf_pkg::S_WAIT)
      else $error("sum mismatch not answered with code 2");
   char_err_a: assert property (last_rx && station_ok && bad_any
      |=> reply_nak && nak_code == alrf_pkg::ERR_CHAR && !req_valid)
      else $error("bad character not answered with code 7");
   delay_digit_a: assert property (last_rx && station_ok && digit_mode
      |=> tmr_load && tmr_ms == 16'(alrf_pkg::hex_val(dly_ch)) * 16'h000a)
      else $error("digit delay not ten ms steps");
   delay_cfg_a: assert property (last_rx && station_ok && !digit_mode
      |=> tmr_load && tmr_ms == $past(reply_wait_time_setting))
      else $error("configured delay not used");
   term_cr_a: assert property (load && pos == body_end && terminator_select_setting[0]
      |=> tx_char == alrf_pkg::CR) else $error("carriage return missing");

   data_reply_c: cover property (tx_done && !reply_nak);
   nak_reply_c: cover property (tx_done && reply_nak);
   host_ack_c: cover property (host_ack);
   resend_c: cover property (host_nak ##[1:40] tx_done);
endmodule
`default_nettype wire

//--- tb/alrf_host_model.sv
// Purpose: behavioural host computer facing the read framer
// Assumes: one character per clock while rx_valid is held high, same clock as the framer
// Notes: slow mode stalls the uart sink on every other cycle
`timescale 1ns/10ps
`default_nettype none
module alrf_host_model
(
   input wire logic clk,
   input wire logic slow,
   output logic tx_ready,
   output logic rx_valid,
   output logic [7:0] rx_char
);
   logic stall = 1'b0;

   initial
   begin
      rx_valid = 1'b0;
      rx_char = 8'h00;
   end

   assign tx_ready = !(slow && stall);

   always @(posedge clk)
      stall <= !stall;

   function automatic logic [7:0] hx(input logic [3:0] v);
      return (v < 4'ha) ? 8'h30 + {4'h0, v} : 8'h37 + {4'h0, v};
   endfunction

   task automatic send(input logic [7:0] c[$]);
      foreach (c[i])
      begin
         @(posedge clk);
         #1;
         rx_valid = 1'b1;
         rx_char = c[i];
      end
      @(posedge clk);
      #1;
      rx_valid = 1'b0;
      // released line shows the inverse so a stale sample cannot pass for data
      rx_char = ~rx_char;
   endtask

   task automatic request(input logic [4:0] st, input logic [15:0] ins, input int digit,
                          input logic bad);
      logic [7:0] q[$];
      logic [7:0] s;
      q = {hx({3'h0, st[4]}), hx(st[3:0]), ins[15:8], ins[7:0]};
      if (digit >= 0)
         q.push_back(hx(digit[3:0]));
      s = 8'h00;
      foreach (q[i])
         s += q[i];
      if (bad)
         s = ~s;
      q = {alrf_pkg::ENQ, q, hx(s[7:4]), hx(s[3:0])};
      send(q);
   endtask

   task automatic answer(input logic [7:0] code, input logic [4:0] st);
      send('{code, hx({3'h0, st[4]}), hx(st[3:0])});
   endtask
endmodule
`default_nettype wire

//--- tb/alrf_read_framer_tb.sv
// Purpose: self-checking bench of the ascii link read framer
// Assumes: framer built with a short millisecond so waits stay brief
// Notes: the bench itself records every character the sink accepts
`timescale 1ns/10ps
`default_nettype none
module alrf_read_framer_tb;
   typedef logic [7:0] alrf_chars_type[$];
   localparam int MSC = 4;
   localparam int DLEN[4] = '{4, 2, 6, 20};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic slow = 1'b0;
   logic rd_done = 1'b0;
   logic err = 1'b0;
   logic [3:0] code = 4'h0;
   logic [4:0] station = 5'h01;
   logic [15:0] setting = 16'h0002;
   logic [1:0] term = 2'h0;
   logic [1:0] fmt = 2'h0;
   logic [159:0] rd_data = "0123456789ABCDEF0123";
   logic rx_valid, tx_ready, tx_valid, req_valid, host_ack, host_nak, busy;
   logic [7:0] rx_char, tx_char;
   logic [15:0] req_instr;
   alrf_chars_type got;
   int err_total, comparisons;

   alrf_read_framer #(.MS_CYCLES(MSC)) dut
   (
      .clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_char(rx_char),
      .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_char(tx_char), .station_id(station),
      .reply_wait_time_setting(setting), .terminator_select_setting(term),
      .req_valid(req_valid), .req_instr(req_instr), .rd_done(rd_done), .rd_format(fmt),
      .rd_data(rd_data), .rd_err(err), .rd_err_code(code), .host_ack(host_ack),
      .host_nak(host_nak), .busy(busy)
   );

   alrf_host_model host
   (
      .clk(clk), .slow(slow), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_char(rx_char)
   );

   always #12.5 clk = ~clk;

   always @(posedge clk)
      if (tx_valid && tx_ready)
         got.push_back(tx_char);

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
      comparisons++;
      if (seen !== want)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, want, seen);
      end
   endtask

   task automatic close_out();
      if (err_total == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   function automatic logic [7:0] hx(input logic [3:0] v);
      return (v < 4'ha) ? 8'h30 + {4'h0, v} : 8'h37 + {4'h0, v};
   endfunction

   // expected frame worked out independently: head, station, body, sum on stx replies only, terminators
   function automatic alrf_chars_type reply(input logic [7:0] head, input alrf_chars_type body);
      alrf_chars_type q;
      logic [7:0] s;
      q = {head, hx({3'h0, station[4]}), hx(station[3:0]), body};
      s = 8'h00;
      if (head == alrf_pkg::STX)
      begin
         foreach (q[i])
            if (i > 0)
               s += q[i];
         q.push_back(hx(s[7:4]));
         q.push_back(hx(s[3:0]));
      end
      if (term[0])
         q.push_back(8'h0d);
      if (term[1])
         q.push_back(8'h0a);
      return q;
   endfunction

   function automatic alrf_chars_type data_chars(input int n);
      alrf_chars_type q;
      for (int i = 0; i < n; i++)
         q.push_back(rd_data[159 - 8 * i -: 8]);
      q.push_back(alrf_pkg::ETX);
      return q;
   endfunction

   // the floor of 150 cycles lets a reply that should never come show up
   task automatic collect(input alrf_chars_type want, output int lat);
      lat = 0;
      for (int n = 0; n < 3000; n++)
      begin
         @(posedge clk);
         #1;
         rd_done = 1'b0;
         if (tx_valid === 1'b1 && lat == 0)
            lat = n + 1;
         if (got.size() >= want.size() && busy === 1'b0 && n > 150)
            break;
      end
      check("reply length", 16'(got.size()), 16'(want.size()));
      foreach (want[i])
         if (i < got.size())
            check("reply char", {8'h00, got[i]}, {8'h00, want[i]});
   endtask

   task automatic xfer(input logic [4:0] st, input logic [15:0] ins, input int digit,
                       input logic bad, input alrf_chars_type want, output int lat);
      got.delete();
      host.request(st, ins, digit, bad);
      if (req_valid === 1'b1)
      begin
         check("instr", req_instr, ins);
         rd_done = 1'b1;
      end
      collect(want, lat);
   endtask

   task automatic s_formats();
      int lat;
      setting = 16'h0002;
      for (int f = 0; f < 4; f++)
      begin
         fmt = f[1:0];
         term = f[1:0];
         slow = f[0];
         xfer(station, 16'h3741, -1, 1'b0, reply(alrf_pkg::STX, data_chars(DLEN[f])),
              lat);
         check("short wait", 16'(lat >= 8 && lat <= 16), 16'h0001);
      end
      slow = 1'b0;
   endtask

   task automatic s_delay();
      int lat;
      setting = 16'h270f;
      fmt = alrf_pkg::FMT_FOUR;
      term = 2'h3;
      xfer(station, 16'h3137, 3, 1'b0, reply(alrf_pkg::STX, data_chars(4)), lat);
      check("digit wait", 16'(lat >= 120 && lat <= 130), 16'h0001);
      setting = 16'h0002;
   endtask

   task automatic s_errors();
      int lat;
      term = 2'h1;
      xfer(station, 16'h3741, -1, 1'b1, reply(alrf_pkg::NAK, '{8'h32}), lat);
      check("nak wait", 16'(lat >= 8 && lat <= 16), 16'h0001);
      xfer(station, 16'h3747, -1, 1'b0, reply(alrf_pkg::NAK, '{8'h37}), lat);
      err = 1'b1;
      code = 4'hb;
      xfer(station, 16'h3741, -1, 1'b0, reply(alrf_pkg::NAK, '{8'h42}), lat);
      err = 1'b0;
   endtask

   task automatic s_host();
      int lat;
      alrf_chars_type want;
      term = 2'h0;
      fmt = alrf_pkg::FMT_TWO;
      want = reply(alrf_pkg::STX, data_chars(2));
      xfer(station, 16'h3741, -1, 1'b0, want, lat);
      got.delete();
      host.answer(alrf_pkg::NAK, station);
      check("host nak", {15'h0, host_nak}, 16'h0001);
      collect(want, lat);
      got.delete();
      host.answer(alrf_pkg::ACK, station);
      check("host ack", {15'h0, host_ack}, 16'h0001);
      collect('{}, lat);
   endtask

   task automatic s_station();
      int lat;
      station = 5'h1f;
      fmt = alrf_pkg::FMT_FOUR;
      xfer(5'h00, 16'h3741, -1, 1'b0, '{}, lat);
      xfer(5'h1f, 16'h3741, -1, 1'b0, reply(alrf_pkg::STX, data_chars(4)), lat);
   endtask

   initial
   begin
      err_total = 0;
      comparisons = 0;
      repeat (8) @(posedge clk);
      #1;
      rst_n = 1'b1;
      check("idle tx", {15'h0, tx_valid}, 16'h0000);
      s_formats();
      s_delay();
      s_errors();
      s_host();
      s_station();
      close_out();
   end

   initial
   begin
      #(25 * 20000);
      err_total++;
      close_out();
   end
endmodule
`default_nettype wire
